// [rtl/i2c_mon_pkg.sv]
`default_nettype none
package i2c_mon_pkg;
    // Register byte addresses
    localparam logic [7:0] STATUS_OFS   = 8'h00;
    localparam logic [7:0] MASK_OFS     = 8'h04;
    localparam logic [7:0] CTRL_OFS     = 8'h08;
    localparam logic [7:0] RD_DATA_OFS  = 8'h0c;
    // Control register fields
    localparam int RR_EN_BIT = 0;
    localparam int TO_EN_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [5:0] FLAGS_RST = 6'h00;
    localparam logic [5:0] MASK_RST  = 6'h00;
    localparam logic LINE_IDLE = 1'b1;
    // Timeout: time in microseconds, cycles derived from the 125 MHz clock
    localparam int CLK_MHZ         = 125;
    localparam int TIMEOUT_US      = 100;
    localparam int TIMEOUT_DFLT    = TIMEOUT_US * CLK_MHZ;
    // Oversampling: cycles per sample and samples per filter window
    localparam int OVS_DIV_DFLT    = 4;
    localparam int OVS_WIN_DFLT    = 8;

    // Flag layout, bit 5 down to bit 0
    typedef struct packed {
        logic acont;
        logic dcont;
        logic glitch;
        logic noise;
        logic rdred;
        logic tmo;
    } flags_s;
endpackage
`default_nettype wire

// [rtl/i2c_bus_fault_monitor.sv]
// Function
// - A filtered SDA level differing from the driven level sets the analog contention flag.
// - Analog contention samples filtered SDA on rising filtered SCL edges, only while SDA is driven.
// - Read data bits from the slave are captured with filtered SDA and SCL.
// - An oversampled line disagreeing with the driven value sets the digital contention flag.
// - Digital contention is checked only while the lines should be settled.
// - Two or more consecutive samples against the filter value set the glitch flag.
// - More than a quarter of a window's samples against the filter value set the noise flag.
// - Glitch and noise monitors look only outside permitted transition intervals.
// - A mismatch between two repeated reads sets the redundant-read error flag.
// - The redundant-read check runs only while its enable is 1.
// - With timeout enabled, an over-long transaction sets the timeout flag.
// - Every flag is sticky, cleared by writing 0, unchanged by writing 1.
// - All flags reset to 0.
`default_nettype none
module i2c_bus_fault_monitor
    import i2c_mon_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_DFLT,
    parameter int OVS_DIV        = OVS_DIV_DFLT,
    parameter int OVS_WIN        = OVS_WIN_DFLT
) (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Bus pins, raw and analog-filtered
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    input  wire logic        scl_filt_pin,
    input  wire logic        sda_filt_pin,
    // From the I2C master
    input  wire logic        scl_drive,
    input  wire logic        scl_drive_en,
    input  wire logic        sda_drive,
    input  wire logic        sda_drive_en,
    input  wire logic        lines_settled,
    input  wire logic        lines_quiet,
    input  wire logic        txn_active,
    input  wire logic        rd_active,
    input  wire logic        rd_start,
    input  wire logic        rd_done,
    input  wire logic        rd_repeat,
    // Results
    output logic [31:0]      rd_data,
    output logic             irq
);
    localparam int CW = $clog2(OVS_WIN + 1);
    localparam int DW = $clog2(OVS_DIV + 1);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Synchronisers: 0 scl, 1 sda, 2 filtered scl, 3 filtered sda
    logic [3:0] sync1_r, sync2_r;
    logic       scl_f_d_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r   <= {4{LINE_IDLE}};
            sync2_r   <= {4{LINE_IDLE}};
            scl_f_d_r <= LINE_IDLE;
        end
        else if (clk_en)
        begin
            sync1_r   <= {sda_filt_pin, scl_filt_pin, sda_pin, scl_pin};
            sync2_r   <= sync1_r;
            scl_f_d_r <= sync2_r[2];
        end
    end

    logic scl_s, sda_s, sda_f, scl_f_rise;
    assign scl_s      = sync2_r[0];
    assign sda_s      = sync2_r[1];
    assign sda_f      = sync2_r[3];
    assign scl_f_rise = sync2_r[2] & ~scl_f_d_r;

    // Oversampling tick and window position
    logic [DW-1:0] div_r, div_nxt;
    logic [CW-1:0] win_r, win_nxt;
    logic          tick, win_end;
    always_comb
    begin
        tick    = (div_r == DW'(OVS_DIV - 1));
        win_end = tick && (win_r == CW'(OVS_WIN - 1));
        div_nxt = tick ? '0 : div_r + DW'(1);
        win_nxt = win_end ? '0 : (tick ? win_r + CW'(1) : win_r);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= '0;
            win_r <= '0;
        end
        else if (clk_en)
        begin
            div_r <= div_nxt;
            win_r <= win_nxt;
        end
    end

    // Digital filter, glitch and noise per line
    logic [1:0] glitch_ev, noise_ev;
    genvar l;
    generate
        for (l = 0; l < 2; l++)
        begin : g_line
            logic          filt_r, filt_nxt, dis;
            logic          run_r, run_nxt;
            logic [CW-1:0] ones_r, ones_nxt, bad_r, bad_nxt;
            logic [CW-1:0] ones_t, bad_t;
            always_comb
            begin
                dis      = sync2_r[l] ^ filt_r;
                ones_t   = ones_r + CW'(sync2_r[l]);
                bad_t    = bad_r + CW'(dis & lines_quiet);
                run_nxt  = run_r;
                ones_nxt = ones_r;
                bad_nxt  = bad_r;
                filt_nxt = filt_r;
                glitch_ev[l] = tick && lines_quiet && dis && run_r;
                noise_ev[l]  = win_end && ({2'b00, bad_t} * 4 > (CW+2)'(OVS_WIN));
                if (tick)
                begin
                    run_nxt  = dis & lines_quiet;
                    ones_nxt = ones_t;
                    bad_nxt  = bad_t;
                end
                if (win_end)
                begin
                    // Majority vote keeps a single stray sample out of the filter
                    filt_nxt = ({1'b0, ones_t} * 2 > (CW+1)'(OVS_WIN));
                    ones_nxt = '0;
                    bad_nxt  = '0;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    filt_r <= LINE_IDLE;
                    run_r  <= 1'b0;
                    ones_r <= '0;
                    bad_r  <= '0;
                end
                else if (clk_en)
                begin
                    filt_r <= filt_nxt;
                    run_r  <= run_nxt;
                    ones_r <= ones_nxt;
                    bad_r  <= bad_nxt;
                end
            end
        end
    endgenerate

    // Read capture, redundant-read compare, timeout counter
    logic [31:0] shift_r, shift_nxt, first_r, first_nxt, rd_data_r, rd_data_nxt;
    logic [31:0] tmo_cnt_r, tmo_cnt_nxt;
    logic [1:0]  ctrl_r, ctrl_nxt;
    flags_s      ev;
    always_comb
    begin
        shift_nxt   = shift_r;
        first_nxt   = first_r;
        rd_data_nxt = rd_data_r;
        if (rd_start)
            shift_nxt = '0;
        else if (rd_active && scl_f_rise)
            shift_nxt = {shift_r[30:0], sda_f};
        if (rd_done)
        begin
            rd_data_nxt = shift_r;
            if (!rd_repeat)
                first_nxt = shift_r;
        end
        tmo_cnt_nxt = '0;
        if (txn_active)
            tmo_cnt_nxt = (tmo_cnt_r == 32'(TIMEOUT_CYCLES)) ? tmo_cnt_r : tmo_cnt_r + 32'd1;
        ev.acont  = scl_f_rise && sda_drive_en && (sda_f != sda_drive);
        ev.dcont  = tick && lines_settled
                    && ((sda_drive_en && sda_s != sda_drive)
                    || (scl_drive_en && scl_s != scl_drive));
        ev.glitch = |glitch_ev;
        ev.noise  = |noise_ev;
        ev.rdred  = ctrl_r[RR_EN_BIT] && rd_done && rd_repeat && (shift_r != first_r);
        ev.tmo    = ctrl_r[TO_EN_BIT] && txn_active
                    && (tmo_cnt_r == 32'(TIMEOUT_CYCLES - 1));
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_r   <= '0;
            first_r   <= '0;
            rd_data_r <= '0;
            tmo_cnt_r <= '0;
        end
        else if (clk_en)
        begin
            shift_r   <= shift_nxt;
            first_r   <= first_nxt;
            rd_data_r <= rd_data_nxt;
            tmo_cnt_r <= tmo_cnt_nxt;
        end
    end

    // APB registers: one wait state, write lands on the pready edge
    flags_s      flags_r, flags_nxt;
    logic [5:0]  mask_r, mask_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        access, hit, wr, st_wr;
    always_comb
    begin
        access = psel && penable;
        hit    = (paddr == STATUS_OFS) || (paddr == MASK_OFS)
                 || (paddr == CTRL_OFS) || (paddr == RD_DATA_OFS);
        wr     = access && pready_r && pwrite && hit;
        st_wr  = wr && (paddr == STATUS_OFS);
        pready_nxt  = access && !pready_r;
        pslverr_nxt = access && !pready_r && !hit;
        prdata_nxt  = '0;
        if (access && !pready_r && !pwrite)
        begin
            unique case (paddr)
                STATUS_OFS:  prdata_nxt = {26'h0, flags_r};
                MASK_OFS:    prdata_nxt = {26'h0, mask_r};
                CTRL_OFS:    prdata_nxt = {30'h0, ctrl_r};
                RD_DATA_OFS: prdata_nxt = rd_data_r;
                default:     prdata_nxt = '0;
            endcase
        end
        mask_nxt = (wr && paddr == MASK_OFS) ? pwdata[5:0] : mask_r;
        ctrl_nxt = (wr && paddr == CTRL_OFS) ? pwdata[1:0] : ctrl_r;
        // Set beats clear so an event in the clearing cycle survives
        flags_nxt = (st_wr ? (flags_r & pwdata[5:0]) : flags_r) | ev;
        irq_nxt   = |(flags_nxt & mask_nxt);
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_r   <= FLAGS_RST;
            mask_r    <= MASK_RST;
            ctrl_r    <= CTRL_RST;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
            irq_r     <= 1'b0;
        end
        else if (clk_en)
        begin
            flags_r   <= flags_nxt;
            mask_r    <= mask_nxt;
            ctrl_r    <= ctrl_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
            irq_r     <= irq_nxt;
        end
    end

    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign prdata  = prdata_r;
    assign irq     = irq_r;
    assign rd_data = rd_data_r;

    acont_set_a: assert property (
        clk_en && scl_f_rise && sda_drive_en && sda_f != sda_drive |=> flags_r.acont)
        else $error("analog contention not flagged");
    acont_cause_a: assert property (
        $rose(flags_r.acont) |-> $past(sda_drive_en && scl_f_rise))
        else $error("analog flag without driven sda on scl edge");
    read_capture_a: assert property (
        clk_en && rd_active && scl_f_rise && !rd_start |=> shift_r[0] == $past(sda_f))
        else $error("read bit not captured from filtered sda");
    dcont_settled_a: assert property (
        $rose(flags_r.dcont) |-> $past(lines_settled && tick))
        else $error("digital contention outside settled interval");
    glitch_quiet_a: assert property (
        $rose(flags_r.glitch) |-> $past(lines_quiet))
        else $error("glitch flagged during transition interval");
    rdred_enable_a: assert property (
        $rose(flags_r.rdred) |-> $past(ctrl_r[RR_EN_BIT] && rd_done && rd_repeat))
        else $error("redundant read flagged while disabled");
    tmo_enable_a: assert property (
        $rose(flags_r.tmo) |-> $past(ctrl_r[TO_EN_BIT] && txn_active))
        else $error("timeout flagged while disabled or idle");
    flag_sticky_a: assert property (
        (|($past(flags_r) & ~flags_r)) |-> $past(st_wr))
        else $error("flag cleared without status write");
    apb_wait_a: assert property (
        clk_en && access && !pready_r |=> pready_r ##1 !pready_r)
        else $error("apb answer not after one wait state");
endmodule
`default_nettype wire

// [sim/i2c_slave_model.sv]
`default_nettype none
module i2c_slave_model (
    // Master drive
    input  wire logic scl_drive,
    input  wire logic scl_drive_en,
    input  wire logic sda_drive,
    input  wire logic sda_drive_en,
    // Slave behaviour
    input  wire logic slave_low,
    input  wire logic spike,
    // Bus levels
    output logic      scl_pin,
    output logic      sda_pin,
    output logic      scl_filt_pin,
    output logic      sda_filt_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_w;
    logic sda_w;
    // Open-drain with pull-ups: a released line goes high
    assign scl_w = !(scl_drive_en && !scl_drive);
    assign sda_w = !(sda_drive_en && !sda_drive) && !slave_low;
    assign scl_pin = scl_w;
    assign sda_pin = sda_w && !spike;
    // Analog filter as a delay; spikes never reach it
    assign #20 scl_filt_pin = scl_w;
    assign #20 sda_filt_pin = sda_w;
endmodule
`default_nettype wire

// [sim/tb.sv]
`default_nettype none
module tb;
    import i2c_mon_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TO_CYC = 20;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        scl_drive, scl_drive_en, sda_drive, sda_drive_en, slave_low, spike, clk_en;
    logic        scl_pin, sda_pin, scl_filt_pin, sda_filt_pin, lines_settled, lines_quiet;
    logic        txn_active, rd_active, rd_start, rd_done, rd_repeat;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_data, q;
    int          fail_count, n_checks;

    i2c_bus_fault_monitor #(.TIMEOUT_CYCLES(TO_CYC), .OVS_DIV(2), .OVS_WIN(8)) DUT (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .scl_pin, .sda_pin, .scl_filt_pin, .sda_filt_pin,
        .scl_drive, .scl_drive_en, .sda_drive, .sda_drive_en, .lines_settled,
        .lines_quiet, .txn_active, .rd_active, .rd_start, .rd_done, .rd_repeat,
        .rd_data, .irq);
    i2c_slave_model bus (.scl_drive, .scl_drive_en, .sda_drive, .sda_drive_en,
        .slave_low, .spike, .scl_pin, .sda_pin, .scl_filt_pin, .sda_filt_pin);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fail_count++;
            print_verdict();
        end
        else
        begin
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // Link clock period 125 ns, so its rising edges fall between pclk edges
    task automatic scl_pulses(input int n);
        repeat (n)
        begin
            scl_drive <= 1'b0;
            #62.5;
            scl_drive <= 1'b1;
            #62.5;
        end
    endtask

    // Slave returns v MSB first while the master clocks SCL
    task automatic read_byte(input logic [7:0] v, input logic rep);
        rd_start <= 1'b1;
        @(posedge pclk);
        rd_start <= 1'b0;
        rd_active <= 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            slave_low <= !v[i];
            scl_pulses(1);
        end
        rd_active <= 1'b0;
        slave_low <= 1'b0;
        cyc(4);
        rd_done <= 1'b1;
        rd_repeat <= rep;
        @(posedge pclk);
        rd_done <= 1'b0;
        rd_repeat <= 1'b0;
        cyc(3);
        chk(rd_data, {24'h0, v});
    endtask

    task automatic t_reset();
        rd_chk(STATUS_OFS, 32'h0);
        rd_chk(MASK_OFS, 32'h0);
        rd_chk(CTRL_OFS, 32'h0);
        rd_chk(RD_DATA_OFS, 32'h0);
        rd_chk(8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask

    task automatic t_analog();
        slave_low <= 1'b1;
        scl_pulses(2);
        rd_chk(STATUS_OFS, 32'h0);
        sda_drive_en <= 1'b1;
        scl_pulses(1);
        sda_drive_en <= 1'b0;
        slave_low <= 1'b0;
        cyc(8);
        apb(1'b1, MASK_OFS, 32'h20);
        cyc(2);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, STATUS_OFS, 32'hffffffff);
        rd_chk(STATUS_OFS, 32'h20);
        apb(1'b1, STATUS_OFS, 32'h0);
        rd_chk(STATUS_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test analog done");
    endtask

    task automatic t_digital();
        sda_drive_en <= 1'b1;
        slave_low <= 1'b1;
        cyc(20);
        rd_chk(STATUS_OFS, 32'h0);
        lines_settled <= 1'b1;
        cyc(20);
        lines_settled <= 1'b0;
        sda_drive_en <= 1'b0;
        slave_low <= 1'b0;
        rd_chk(STATUS_OFS, 32'h10);
        apb(1'b1, STATUS_OFS, 32'h0);
        $display("test digital done");
    endtask

    task automatic t_glitch();
        spike <= 1'b1;
        cyc(12);
        spike <= 1'b0;
        // Let the majority filter recover from the spike before quiet starts
        cyc(40);
        lines_quiet <= 1'b1;
        cyc(40);
        rd_chk(STATUS_OFS, 32'h0);
        spike <= 1'b1;
        cyc(12);
        spike <= 1'b0;
        cyc(40);
        lines_quiet <= 1'b0;
        rd_chk(STATUS_OFS, 32'h0c);
        apb(1'b1, STATUS_OFS, 32'h0);
        $display("test glitch done");
    endtask

    task automatic t_rdred();
        read_byte(8'ha5, 1'b0);
        read_byte(8'h5a, 1'b1);
        rd_chk(STATUS_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        read_byte(8'ha5, 1'b0);
        read_byte(8'ha5, 1'b1);
        rd_chk(STATUS_OFS, 32'h0);
        read_byte(8'ha5, 1'b0);
        read_byte(8'h3c, 1'b1);
        rd_chk(STATUS_OFS, 32'h02);
        rd_chk(RD_DATA_OFS, 32'h3c);
        apb(1'b1, STATUS_OFS, 32'h0);
        $display("test redundant read done");
    endtask

    task automatic t_timeout();
        apb(1'b1, CTRL_OFS, 32'h0);
        txn_active <= 1'b1;
        cyc(30);
        txn_active <= 1'b0;
        rd_chk(STATUS_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h2);
        txn_active <= 1'b1;
        cyc(TO_CYC - 5);
        txn_active <= 1'b0;
        rd_chk(STATUS_OFS, 32'h0);
        // Frozen clock enable must stop the timeout counter
        clk_en <= 1'b0;
        txn_active <= 1'b1;
        cyc(TO_CYC + 5);
        txn_active <= 1'b0;
        clk_en <= 1'b1;
        rd_chk(STATUS_OFS, 32'h0);
        txn_active <= 1'b1;
        cyc(TO_CYC + 5);
        txn_active <= 1'b0;
        rd_chk(STATUS_OFS, 32'h01);
        $display("test timeout done");
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, slave_low, spike} = '0;
        {scl_drive, scl_drive_en, sda_drive, sda_drive_en} = 4'hf;
        sda_drive_en = 1'b0;
        clk_en = 1'b1;
        {lines_settled, lines_quiet, txn_active, rd_active} = '0;
        {rd_start, rd_done, rd_repeat} = '0;
        fail_count = 0;
        n_checks = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_analog();
        t_digital();
        t_glitch();
        t_rdred();
        t_timeout();
        print_verdict();
    end
endmodule
`default_nettype wire
